// ### rtl/lmfr_pkg.sv
package lmfr_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFF_LINK_CONFIG   = 8'h07;
   localparam logic [7:0] OFF_TIMEOUT_STATE = 8'h08;
   localparam logic [7:0] OFF_FORCE_CLOSED  = 8'h09;
   localparam logic [7:0] OFF_GROUP_ONE     = 8'h0a;
   localparam logic [7:0] OFF_GROUP_TWO     = 8'h0b;
   localparam logic [7:0] OFF_SOURCE_MASK   = 8'h0c;
   localparam logic [7:0] OFF_LAMP_MASK     = 8'h0d;
   localparam logic [7:0] OFF_DECODE_STATUS = 8'h0e;
   localparam logic [7:0] OFF_DECODE_CODES  = 8'h0f;
   localparam logic [7:0] OFF_GEN_STATUS    = 8'h10;
   localparam logic [7:0] OFF_LINK_STATUS   = 8'h11;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int TMO_SEL_LSB   = 6;
   localparam int CLUSTER_ID_LSB = 0;
   localparam int OT_ACTION_BIT = 12;
   localparam int MSK_LINK_BIT  = 6;
   localparam int MSK_OPEN_BIT  = 4;
   localparam int MSK_SHORT_BIT = 3;
   localparam int MSK_PUMP_BIT  = 2;
   localparam int MSK_DEC_BIT   = 1;
   localparam int MSK_WARN_BIT  = 0;
   localparam int GS_CRC_BIT    = 10;
   localparam int GS_CFG_BIT    = 9;
   localparam int GS_DEC_BIT    = 8;
   localparam int GS_CLK_BIT    = 7;
   localparam int GS_LINK_BIT   = 6;
   localparam int GS_OPEN_BIT   = 4;
   localparam int GS_SHORT_BIT  = 3;
   localparam int GS_PUMP_BIT   = 2;
   localparam int GS_SHDN_BIT   = 1;
   localparam int GS_WARN_BIT   = 0;
   localparam int LS_WDOG_BIT   = 8;
   // ****************************************
   // Reset values and group codes
   // ****************************************
   localparam logic [5:0]  CLUSTER_ID_RESET = 6'h01;
   localparam logic [3:0]  TMO_OFF     = 4'h0;
   localparam logic [12:0] ZERO13      = 13'h0000;
   localparam logic [3:0]  GROUP_ONE_CODE = 4'h1;
   localparam logic [3:0]  GROUP_TWO_CODE = 4'h2;
   // ****************************************
   // Watchdog durations, microseconds, and cycles at 100 MHz
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int WD_US [16] = '{0, 200, 500, 1000, 2000, 5000, 10000, 20000, 50000,
      100000, 200000, 500000, 1000000, 2000000, 5000000, 5000000};
   localparam int WD_CYC_PER_US = CLK_MHZ;
endpackage

// ### rtl/lmfr_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RULE1 - Nonzero timeout select and no valid command in time sets watchdog flag.
// RULE2 - Watchdog flag drives fault low and applies timeout switch states.
// RULE3 - Timeout codes 1..15 map 200us up to 5s, last two both 5s.
// RULE4 - Cluster write accepted only when received ID matches stored ID, reset one.
// RULE5 - Timeout switch state bit per switch: 0 open, 1 closed.
// RULE6 - Forced-closed override bit holds that switch closed regardless of dimming.
// RULE7 - Group one members take group code 0001 writes and group one duty.
// RULE8 - Group two members take group code 0010 writes and group two duty.
// RULE9 - Thermal shutdown closes all switches if action 0, opens all if 1.
// RULE10 - Source mask bits block link, open, short, pump, decode, warning faults.
// RULE11 - Per-lamp mask keeps that lamp's open and short from fault output.
// RULE12 - Decode status shows done and over/under range flags, reset zero.
// RULE13 - Decoded codes: node number bits 7:4, grade code bits 3:0.
// RULE14 - Fault output asserted when any permitted unmasked status bit is high.
// RULE15 - Bit 10 flags memory CRC error, status only, no fault.
// RULE16 - Bit 9 high while switch configuration incomplete; host waits for low.
// RULE17 - Bit 8 high until grade read completes; asserts fault.
// RULE18 - Bit 7 set when outside clock selected and running too slow.
// RULE19 - Bit 6 is OR of link receive error flags.
// RULE20 - Bit 4 any lamp open, bit 3 any lamp short.
// RULE21 - Bit 2 high while charge pump below threshold.
// RULE22 - Shutdown and warning flags latch, clear by writing one.
// RULE23 - Watchdog flag at link status bit 8, cleared by writing one.
// RULE24 - Unused bits read zero, writes to them ignored.
module lmfr_regs
   import lmfr_pkg::*;
#(
   parameter int N_SW = 12
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // Register port from link engine
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [12:0]     reg_wdata,
   output logic      [12:0]     reg_rdata,
   // Link events
   input  wire logic            cmd_valid,
   input  wire logic            cluster_call,
   input  wire logic [5:0]      cluster_rx_id,
   output logic                 cluster_accept,
   input  wire logic [6:0]      link_rx_errors,
   // Group write qualification
   input  wire logic [3:0]      group_code,
   output logic      [N_SW-1:0] group_hit,
   output logic      [N_SW-1:0] set_one_members,
   output logic      [N_SW-1:0] set_two_members,
   // Switch control
   input  wire logic [N_SW-1:0] dim_switch_closed,
   output logic      [N_SW-1:0] switch_closed,
   // Analog status pins
   input  wire logic            heat_shutdown_evt,
   input  wire logic            heat_warning_evt,
   input  wire logic            pump_not_ready_pin,
   input  wire logic            outside_clock_slow_pin,
   input  wire logic [1:0]      clock_source_sel,
   input  wire logic            crc_error_pin,
   input  wire logic            config_busy,
   input  wire logic [4:0]      decode_status_in,
   input  wire logic            decode_incomplete_in,
   input  wire logic [3:0]      address_resistor,
   input  wire logic [3:0]      grade_code,
   input  wire logic [N_SW-1:0] per_lamp_open_flags,
   input  wire logic [N_SW-1:0] per_lamp_short_flags,
   // Outputs
   output logic      [3:0]      node_number,
   output logic                 fault_out_n
);
   // ****************************************
   // Pin synchronisers, three stages
   // ****************************************
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] s1;
   logic [NSYNC-1:0] s2;
   logic [NSYNC-1:0] s3;
   logic [NSYNC-1:0] pin_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         pin_q <= '0;
      end else begin
         s1 <= {heat_shutdown_evt, heat_warning_evt, pump_not_ready_pin,
                outside_clock_slow_pin, crc_error_pin};
         s2 <= s1;
         s3 <= s2;
         // Change accepted only once two stages agree
         for (int i = 0; i < NSYNC; i++) begin
            if (s2[i] == s3[i]) begin
               pin_q[i] <= s3[i];
            end
         end
      end
   end
   logic shdn_in;
   logic warn_in;
   logic pump_in;
   logic slow_in;
   logic crc_in;
   assign {shdn_in, warn_in, pump_in, slow_in, crc_in} = pin_q;

   // ****************************************
   // Configuration registers
   // ****************************************
   logic [3:0]      silence_timeout_sel;
   logic [5:0]      cluster_match_id;
   logic [N_SW-1:0] timeout_switch_state;
   logic [N_SW-1:0] force_bypass_closed;
   logic [N_SW-1:0] per_lamp_fault_mask;
   logic [12:0]     fault_source_mask;
   logic            wr_link;
   logic            wr_gen;
   assign wr_link = reg_wr && reg_addr == OFF_LINK_STATUS;
   assign wr_gen  = reg_wr && reg_addr == OFF_GEN_STATUS;

   always_ff @(posedge clk) begin
      if (rst) begin
         silence_timeout_sel  <= TMO_OFF;
         cluster_match_id     <= CLUSTER_ID_RESET;  // [RULE4]
         timeout_switch_state <= '0;
         force_bypass_closed  <= '0;
         set_one_members      <= '0;
         set_two_members      <= '0;
         per_lamp_fault_mask  <= '0;
         fault_source_mask    <= ZERO13;
      end else if (reg_wr) begin
         case (reg_addr)
            OFF_LINK_CONFIG: begin
               silence_timeout_sel <= reg_wdata[TMO_SEL_LSB+:4];
               cluster_match_id    <= reg_wdata[CLUSTER_ID_LSB+:6];
            end
            OFF_TIMEOUT_STATE: timeout_switch_state <= reg_wdata[N_SW-1:0];
            OFF_FORCE_CLOSED:  force_bypass_closed  <= reg_wdata[N_SW-1:0];
            OFF_GROUP_ONE:     set_one_members      <= reg_wdata[N_SW-1:0];
            OFF_GROUP_TWO:     set_two_members      <= reg_wdata[N_SW-1:0];
            OFF_LAMP_MASK:     per_lamp_fault_mask  <= reg_wdata[N_SW-1:0];
            // Only the documented mask bits and action bit are kept
            OFF_SOURCE_MASK: begin
               fault_source_mask <= reg_wdata & 13'h105f;  // [RULE24]
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Link watchdog
   // ****************************************
   logic [31:0] wd_count;
   logic        link_watchdog;
   logic [31:0] wd_limit;
   assign wd_limit = 32'(WD_US[silence_timeout_sel] * WD_CYC_PER_US);  // [RULE3]
   always_ff @(posedge clk) begin
      if (rst || cmd_valid || silence_timeout_sel == TMO_OFF) begin
         wd_count <= '0;
      end else if (wd_count < wd_limit) begin
         wd_count <= wd_count + 32'd1;
      end
   end
   // Set wins over clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         link_watchdog <= 1'b0;
      end else if (silence_timeout_sel != TMO_OFF && !cmd_valid
                   && wd_count + 32'd1 >= wd_limit) begin
         link_watchdog <= 1'b1;  // [RULE1]
      end else if (wr_link && reg_wdata[LS_WDOG_BIT]) begin
         link_watchdog <= 1'b0;  // [RULE23]
      end
   end

   // ****************************************
   // Cluster match and group hits
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         cluster_accept <= 1'b0;
         group_hit      <= '0;
      end else begin
         cluster_accept <= cluster_call && cluster_rx_id == cluster_match_id;  // [RULE4]
         group_hit <= ({N_SW{group_code == GROUP_ONE_CODE}} & set_one_members)   // [RULE7]
                    | ({N_SW{group_code == GROUP_TWO_CODE}} & set_two_members);  // [RULE8]
      end
   end

   // ****************************************
   // Latched thermal flags
   // ****************************************
   logic heat_shutdown;
   logic heat_warning;
   always_ff @(posedge clk) begin
      if (rst) begin
         heat_shutdown <= 1'b0;
         heat_warning  <= 1'b0;
      end else begin
         if (shdn_in) begin
            heat_shutdown <= 1'b1;  // [RULE22]
         end else if (wr_gen && reg_wdata[GS_SHDN_BIT]) begin
            heat_shutdown <= 1'b0;
         end
         if (warn_in) begin
            heat_warning <= 1'b1;  // [RULE22]
         end else if (wr_gen && reg_wdata[GS_WARN_BIT]) begin
            heat_warning <= 1'b0;
         end
      end
   end

   // ****************************************
   // Status composition
   // ****************************************
   logic [N_SW-1:0] lamp_open_m;
   logic [N_SW-1:0] lamp_short_m;
   logic            lamp_open_any;
   logic            lamp_short_any;
   logic            link_error;
   logic            outside_clock_slow;
   logic [12:0]     gen_status;
   assign lamp_open_any  = |per_lamp_open_flags;  // [RULE20]
   assign lamp_short_any = |per_lamp_short_flags;  // [RULE20]
   assign link_error     = |link_rx_errors;  // [RULE19]
   assign outside_clock_slow = clock_source_sel[1] && slow_in;  // [RULE18]
   assign lamp_open_m  = per_lamp_open_flags & ~per_lamp_fault_mask;  // [RULE11]
   assign lamp_short_m = per_lamp_short_flags & ~per_lamp_fault_mask;  // [RULE11]
   always_comb begin
      gen_status = '0;
      gen_status[GS_CRC_BIT]   = crc_in;  // [RULE15]
      gen_status[GS_CFG_BIT]   = config_busy;  // [RULE16]
      gen_status[GS_DEC_BIT]   = decode_incomplete_in;  // [RULE17]
      gen_status[GS_CLK_BIT]   = outside_clock_slow;
      gen_status[GS_LINK_BIT]  = link_error;
      gen_status[GS_OPEN_BIT]  = lamp_open_any;
      gen_status[GS_SHORT_BIT] = lamp_short_any;
      gen_status[GS_PUMP_BIT]  = pump_in;  // [RULE21]
      gen_status[GS_SHDN_BIT]  = heat_shutdown;
      gen_status[GS_WARN_BIT]  = heat_warning;
   end

   // ****************************************
   // Fault output; crc and config bits excluded
   // ****************************************
   logic fault_any;
   assign fault_any = link_watchdog  // [RULE2]
      || (decode_incomplete_in && !fault_source_mask[MSK_DEC_BIT])  // [RULE17]
      || outside_clock_slow  // [RULE14]
      || (link_error && !fault_source_mask[MSK_LINK_BIT])  // [RULE10]
      || (|lamp_open_m && !fault_source_mask[MSK_OPEN_BIT])
      || (|lamp_short_m && !fault_source_mask[MSK_SHORT_BIT])
      || (pump_in && !fault_source_mask[MSK_PUMP_BIT])
      || heat_shutdown
      || (heat_warning && !fault_source_mask[MSK_WARN_BIT]);
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_out_n <= 1'b1;
      end else begin
         fault_out_n <= !fault_any;  // [RULE14]
      end
   end

   // ****************************************
   // Switch drive, priority: shutdown, watchdog, override, dimming
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         switch_closed <= '1;
      end else if (heat_shutdown) begin
         switch_closed <= {N_SW{!fault_source_mask[OT_ACTION_BIT]}};  // [RULE9]
      end else if (link_watchdog) begin
         switch_closed <= timeout_switch_state;  // [RULE2] [RULE5]
      end else begin
         switch_closed <= dim_switch_closed | force_bypass_closed;  // [RULE6]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         node_number <= '0;
      end else begin
         node_number <= address_resistor;  // [RULE13]
      end
   end

   // ****************************************
   // Read mux, unused bits zero
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            OFF_LINK_CONFIG:   reg_rdata <= {3'h0, silence_timeout_sel, cluster_match_id};
            OFF_TIMEOUT_STATE: reg_rdata <= {1'b0, timeout_switch_state};
            OFF_FORCE_CLOSED:  reg_rdata <= {1'b0, force_bypass_closed};
            OFF_GROUP_ONE:     reg_rdata <= {1'b0, set_one_members};
            OFF_GROUP_TWO:     reg_rdata <= {1'b0, set_two_members};
            OFF_SOURCE_MASK:   reg_rdata <= fault_source_mask;
            OFF_LAMP_MASK:     reg_rdata <= {1'b0, per_lamp_fault_mask};
            OFF_DECODE_STATUS: reg_rdata <= {8'h00, decode_status_in};  // [RULE12]
            OFF_DECODE_CODES:  reg_rdata <= {5'h00, address_resistor, grade_code};  // [RULE13]
            OFF_GEN_STATUS:    reg_rdata <= gen_status;
            OFF_LINK_STATUS:   reg_rdata <= {4'h0, link_watchdog, 8'h00};
            default:           reg_rdata <= '0;  // [RULE24]
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_wd_fault;
      @(posedge clk) disable iff (rst) link_watchdog |=> !fault_out_n;
   endproperty
   a_wd_fault: assert property (p_wd_fault) else $error("watchdog without fault");  // [RULE2]
   property p_wd_off;
      @(posedge clk) disable iff (rst)
         (silence_timeout_sel == TMO_OFF && !link_watchdog) |=> !link_watchdog;
   endproperty
   a_wd_off: assert property (p_wd_off) else $error("disabled watchdog fired");  // [RULE1]
   property p_shdn_sw;
      @(posedge clk) disable iff (rst)
         heat_shutdown |=> switch_closed == {N_SW{!$past(fault_source_mask[OT_ACTION_BIT])}};
   endproperty
   a_shdn_sw: assert property (p_shdn_sw) else $error("shutdown switch state wrong");  // [RULE9]
   property p_override;
      @(posedge clk) disable iff (rst)
         (!heat_shutdown && !link_watchdog) |=>
            ((switch_closed & $past(force_bypass_closed)) == $past(force_bypass_closed));
   endproperty
   a_override: assert property (p_override) else $error("override not closed");  // [RULE6]
   property p_cluster;
      @(posedge clk) disable iff (rst)
         (cluster_call && cluster_rx_id != cluster_match_id) |=> !cluster_accept;
   endproperty
   a_cluster: assert property (p_cluster) else $error("cluster mismatch accepted");  // [RULE4]
   property p_warn_latch;
      @(posedge clk) disable iff (rst)
         (heat_warning && !(wr_gen && reg_wdata[GS_WARN_BIT])) |=> heat_warning;
   endproperty
   a_warn_latch: assert property (p_warn_latch) else $error("warning lost");  // [RULE22]
   property p_crc_quiet;
      @(posedge clk) disable iff (rst)
         (!fault_any && $rose(crc_in)) |=> fault_out_n;
   endproperty
   a_crc_quiet: assert property (p_crc_quiet) else $error("crc drove fault");  // [RULE15]
   property p_dec_fault;
      @(posedge clk) disable iff (rst)
         (decode_incomplete_in && !fault_source_mask[MSK_DEC_BIT]) |=> !fault_out_n;
   endproperty
   a_dec_fault: assert property (p_dec_fault) else $error("decode fault missing");  // [RULE17]
   property p_slow_fault;
      @(posedge clk) disable iff (rst)
         (slow_in && clock_source_sel[1]) |=> !fault_out_n;
   endproperty
   a_slow_fault: assert property (p_slow_fault) else $error("slow clock quiet");  // [RULE18]
   property p_wd_state;
      @(posedge clk) disable iff (rst)
         (link_watchdog && !heat_shutdown) |=> switch_closed == $past(timeout_switch_state);
   endproperty
   a_wd_state: assert property (p_wd_state) else $error("wd state not applied");  // [RULE5]
   property p_group_one;
      @(posedge clk) disable iff (rst)
         (group_code == GROUP_ONE_CODE) |=> group_hit == $past(set_one_members);
   endproperty
   a_group_one: assert property (p_group_one) else $error("group one hit wrong");  // [RULE7]
endmodule
`default_nettype wire

// ### dv/lmfr_host.sv
`timescale 1ns/1ns
`default_nettype none
module lmfr_host (
   // Clock
   input  wire logic        clk,
   // Register port
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [7:0]       reg_addr,
   output logic [12:0]      reg_wdata,
   input  wire logic [12:0] reg_rdata,
   // Stuck poll flag
   output logic             timed_out
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hff;
      reg_wdata = 13'h0000;
      timed_out = 1'b0;
   end
   task automatic rd(input logic [7:0] a, output logic [12:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
      reg_addr = ~a;
   endtask
   task automatic wr(input logic [7:0] a, input logic [12:0] d);
      logic [12:0] st;
      int          n;
      // General setup writes wait for the previous programming to finish
      if (a >= 8'h02 && a <= 8'h06) begin
         st = 13'h0200;
         n = 0;
         while (st[9] !== 1'b0 && n < 64) begin
            rd(8'h10, st);
            n++;
         end
         if (n == 64) timed_out = 1'b1;
      end
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import lmfr_pkg::*;
   typedef struct packed {
      logic [7:0]  a;
      logic [12:0] w;
      logic [12:0] e;
   } lmfr_row_t;
   // ****************************************
   // Signals
   // ****************************************
   logic clk = 1'b0, rst = 1'b1, reg_wr, reg_rd, cmd_valid = 1'b0;
   logic cluster_call = 1'b0, cluster_accept, fault_out_n, hsd = 1'b0;
   logic hwn = 1'b0, pump = 1'b0, crc = 1'b0, busy = 1'b0, dinc = 1'b0;
   logic timed_out, slow = 1'b0;
   logic [1:0]  csel = 2'h0;
   logic [7:0]  reg_addr;
   logic [12:0] reg_wdata, reg_rdata, rv;
   logic [5:0]  rx_id = 6'h00;
   logic [6:0]  rx_err = 7'h00;
   logic [3:0]  gcode = 4'h0, node_number;
   logic [4:0]  dstat = 5'h15;
   logic [11:0] hit, one_m, two_m, sw, dim = 12'h000, opn = 12'h000, shr = 12'h000;
   int err_count = 0, num_checks = 0;
   localparam int WD_LIM = 200 * 100;
   localparam lmfr_row_t ROWS [10] = '{
      '{8'h07, 13'h1fff, 13'h03ff}, '{8'h08, 13'h1fff, 13'h0fff},
      '{8'h09, 13'h1fff, 13'h0fff}, '{8'h0a, 13'h1fff, 13'h0fff},
      '{8'h0b, 13'h1fff, 13'h0fff}, '{8'h0c, 13'h1fff, 13'h105f},
      '{8'h0d, 13'h1fff, 13'h0fff}, '{8'h0e, 13'h1fff, 13'h0015},
      '{8'h0f, 13'h1fff, 13'h00a5}, '{8'h05, 13'h1fff, 13'h0000}};
   always #5 clk = ~clk;
   lmfr_host lmfr_host_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .timed_out(timed_out));
   lmfr_regs lmfr_regs_i (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .cmd_valid(cmd_valid), .cluster_call(cluster_call), .cluster_rx_id(rx_id),
      .cluster_accept(cluster_accept), .link_rx_errors(rx_err), .group_code(gcode),
      .group_hit(hit), .set_one_members(one_m), .set_two_members(two_m),
      .dim_switch_closed(dim), .switch_closed(sw), .heat_shutdown_evt(hsd),
      .heat_warning_evt(hwn), .pump_not_ready_pin(pump),
      .outside_clock_slow_pin(slow), .clock_source_sel(csel), .crc_error_pin(crc),
      .config_busy(busy), .decode_status_in(dstat), .decode_incomplete_in(dinc),
      .address_resistor(4'ha), .grade_code(4'h5), .per_lamp_open_flags(opn),
      .per_lamp_short_flags(shr), .node_number(node_number),
      .fault_out_n(fault_out_n));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [12:0] s, input logic [12:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Async pins pass a synchroniser, so allow settling
   task automatic fault_is(input logic e);
      tick(8);
      chk({12'h000, fault_out_n}, {12'h000, e});
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [12:0] e);
      lmfr_host_i.rd(a, rv);
      chk(rv, e);
   endtask
   always @(posedge timed_out) begin
      err_count++;
      summarize();
   end
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      tick(15);
      chk({1'b0, sw}, 13'h0fff);
      chk({12'h000, fault_out_n}, 13'h0001);
      tick(1);
      rst = 1'b0;
      lmfr_host_i.rd(8'h07, rv);
      chk({7'h00, rv[5:0]}, {7'h00, CLUSTER_ID_RESET});
      for (int i = 8'h09; i <= 8'h0d; i++) rdchk(i[7:0], ZERO13);
      for (int i = 0; i < 10; i++) begin
         lmfr_host_i.wr(ROWS[i].a, ROWS[i].w);
         rdchk(ROWS[i].a, ROWS[i].e);
      end
      chk({9'h000, node_number}, 13'h000a);
      lmfr_host_i.wr(8'h07, 13'h0000);
      lmfr_host_i.wr(8'h09, 13'h0000);
      lmfr_host_i.wr(8'h0c, 13'h0000);
      lmfr_host_i.wr(8'h0d, 13'h0000);
      rx_err = 7'h01;
      fault_is(1'b0);
      rdchk(8'h10, 13'h0040);
      lmfr_host_i.wr(8'h0c, 13'h0040);
      fault_is(1'b1);
      rx_err = 7'h00;
      lmfr_host_i.wr(8'h0c, 13'h0000);
      opn = 12'h008;
      fault_is(1'b0);
      rdchk(8'h10, 13'h0010);
      lmfr_host_i.wr(8'h0d, 13'h0008);
      fault_is(1'b1);
      opn = 12'h000;
      shr = 12'h004;
      fault_is(1'b0);
      rdchk(8'h10, 13'h0008);
      lmfr_host_i.wr(8'h0c, 13'h0008);
      fault_is(1'b1);
      shr = 12'h000;
      pump = 1'b1;
      lmfr_host_i.wr(8'h0c, 13'h0000);
      fault_is(1'b0);
      rdchk(8'h10, 13'h0004);
      lmfr_host_i.wr(8'h0c, 13'h0004);
      fault_is(1'b1);
      pump = 1'b0;
      dinc = 1'b1;
      lmfr_host_i.wr(8'h0c, 13'h0000);
      fault_is(1'b0);
      rdchk(8'h10, 13'h0100);
      lmfr_host_i.wr(8'h0c, 13'h0002);
      fault_is(1'b1);
      dinc = 1'b0;
      crc = 1'b1;
      busy = 1'b1;
      fault_is(1'b1);
      rdchk(8'h10, 13'h0600);
      crc = 1'b0;
      busy = 1'b0;
      slow = 1'b1;
      fault_is(1'b1);
      csel = 2'h2;
      fault_is(1'b0);
      rdchk(8'h10, 13'h0080);
      csel = 2'h3;
      fault_is(1'b0);
      slow = 1'b0;
      csel = 2'h0;
      fault_is(1'b1);
      hwn = 1'b1;
      lmfr_host_i.wr(8'h0c, 13'h0000);
      tick(8);
      hwn = 1'b0;
      fault_is(1'b0);
      rdchk(8'h10, 13'h0001);
      lmfr_host_i.wr(8'h10, 13'h0001);
      rdchk(8'h10, 13'h0000);
      lmfr_host_i.wr(8'h09, 13'h0005);
      tick(2);
      chk({1'b0, sw}, 13'h0005);
      dim = 12'h030;
      tick(2);
      chk({1'b0, sw}, 13'h0035);
      hsd = 1'b1;
      fault_is(1'b0);
      chk({1'b0, sw}, 13'h0fff);
      lmfr_host_i.wr(8'h0c, 13'h1000);
      tick(2);
      chk({1'b0, sw}, 13'h0000);
      hsd = 1'b0;
      dim = 12'h000;
      tick(8);
      lmfr_host_i.wr(8'h10, 13'h0002);
      rdchk(8'h10, 13'h0000);
      lmfr_host_i.wr(8'h0c, 13'h0000);
      lmfr_host_i.wr(8'h07, 13'h002a);
      cluster_call = 1'b1;
      rx_id = 6'h2a;
      tick(1);
      chk({12'h000, cluster_accept}, 13'h0001);
      rx_id = 6'h2b;
      tick(1);
      chk({12'h000, cluster_accept}, 13'h0000);
      cluster_call = 1'b0;
      lmfr_host_i.wr(8'h0a, 13'h00f0);
      lmfr_host_i.wr(8'h0b, 13'h000f);
      gcode = GROUP_ONE_CODE;
      tick(1);
      chk({1'b0, hit}, 13'h00f0);
      chk({1'b0, one_m}, 13'h00f0);
      gcode = GROUP_TWO_CODE;
      tick(1);
      chk({1'b0, hit}, 13'h000f);
      chk({1'b0, two_m}, 13'h000f);
      gcode = 4'h0;
      lmfr_host_i.wr(8'h08, 13'h00a5);
      lmfr_host_i.wr(8'h07, 13'h0040);
      cmd_valid = 1'b1;
      tick(1);
      cmd_valid = 1'b0;
      tick(WD_LIM - 1000);
      chk({1'b0, sw}, 13'h0005);
      tick(2000);
      chk({1'b0, sw}, 13'h00a5);
      fault_is(1'b0);
      rdchk(8'h11, 13'h0100);
      lmfr_host_i.wr(8'h07, 13'h0000);
      lmfr_host_i.wr(8'h11, 13'h0100);
      rdchk(8'h11, 13'h0000);
      fault_is(1'b1);
      // Mid-run reset must restore the documented reset values
      rst = 1'b1;
      tick(2);
      chk({1'b0, sw}, 13'h0fff);
      chk({12'h000, fault_out_n}, 13'h0001);
      rst = 1'b0;
      rdchk(8'h07, 13'h0001);
      rdchk(8'h0a, 13'h0000);
      summarize();
   end
endmodule
`default_nettype wire
